/* rtl/frcct_pkg.sv */
`default_nettype none
package frcct_pkg;
  // Byte register indices on the plain register port
  localparam logic [4:0] ADDR_CNT_HI    = 5'h00;
  localparam logic [4:0] ADDR_CNT_LO    = 5'h01;
  localparam logic [4:0] ADDR_ALT_HI    = 5'h02;
  localparam logic [4:0] ADDR_ALT_LO    = 5'h03;
  localparam logic [4:0] ADDR_CAP1_HI   = 5'h04;
  localparam logic [4:0] ADDR_CAP1_LO   = 5'h05;
  localparam logic [4:0] ADDR_CAP2_HI   = 5'h06;
  localparam logic [4:0] ADDR_CAP2_LO   = 5'h07;
  localparam logic [4:0] ADDR_CMP1_HI   = 5'h08;
  localparam logic [4:0] ADDR_CMP1_LO   = 5'h09;
  localparam logic [4:0] ADDR_CMP2_HI   = 5'h0a;
  localparam logic [4:0] ADDR_CMP2_LO   = 5'h0b;
  localparam logic [4:0] ADDR_CTRL_ONE  = 5'h0c;
  localparam logic [4:0] ADDR_CTRL_TWO  = 5'h0d;
  localparam logic [4:0] ADDR_STATUS    = 5'h0e;

  // control_reg_one fields
  localparam int C1_OVF_IE   = 0;
  localparam int C1_CAP_IE   = 1;
  localparam int C1_CMP_IE   = 2;
  localparam int C1_CAP1_EDG = 3;
  localparam int C1_OLVL1    = 4;
  localparam int C1_OLVL2    = 5;
  // control_reg_two fields
  localparam int C2_CLK_LSB  = 0;
  localparam int C2_EXT_EDG  = 2;
  localparam int C2_CAP2_EDG = 3;
  localparam int C2_CMP1_OE  = 4;
  localparam int C2_CMP2_OE  = 5;
  localparam int C2_OPM      = 6;
  localparam int C2_PWM      = 7;
  // timer_status_reg fields
  localparam int ST_CAP1 = 0;
  localparam int ST_CAP2 = 1;
  localparam int ST_CMP1 = 2;
  localparam int ST_CMP2 = 3;
  localparam int ST_OVF  = 4;

  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CNT_TOP    = 16'hffff;
  localparam logic [15:0] CMP_RESET  = 16'h8000;
  localparam logic [1:0]  CLK_EXT    = 2'h3;
  localparam logic [2:0]  DIV2_MASK  = 3'h1;
  localparam logic [2:0]  DIV4_MASK  = 3'h3;
  localparam logic [2:0]  DIV8_MASK  = 3'h7;
endpackage
`default_nettype wire

/* rtl/frcct_timer.sv */
// Contract
// (R1) 16-bit free running up counter, byte registers
// (R2) High byte read latches low byte until read
// (R3) Lone low byte read returns live count
// (R4) Low byte write reloads FFFCh, also reset
// (R5) Clock select divides by 2, 4, 8
// (R6) Select value 3 uses external clock
// (R7) Edge select bit picks external active edge
// (R8) External edges synchronised to processor clock
// (R9) External clock slower than quarter processor clock
// (R10) Rollover FFFFh to 0000h sets overflow flag
// (R11) Overflow irq needs enable and clear mask
// (R12) Status read then main low access clears overflow
// (R13) Runs in wait, freezes in halt
// (R14) Capture edge copies counter, sets capture flag
// (R15) Capture irq needs enable and clear mask
// (R16) Status read then capture low access clears
// (R17) Capture high read blocks captures until low
// (R18) Capture register keeps latest accepted value
// (R19) Pulse modes leave only capture two normal
// (R20) Capture pins always feed capture logic
// (R21) Compare match sets flag, pin, interrupt
// (R22) Compare registers software only, reset 8000h
// (R23) All requests ORed onto one interrupt line
`default_nettype none
module frcct_timer (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       halt,
  input  wire logic       global_irq_mask,
  input  wire logic       ext_clock_pin,
  input  wire logic [1:0] capture_pin,
  output logic      [1:0] compare_pin,
  output logic      [1:0] compare_pin_oe_n,
  output logic            timer_irq
);

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  lo_buf;
    logic        lo_held;
    logic [2:0]  presc;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic [1:0]  cap_prev;
    logic [15:0] cap1;
    logic [15:0] cap2;
    logic [1:0]  cap_block;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [1:0]  cmp_block;
    logic [1:0]  pin;
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [4:0]  status;
    logic [4:0]  armed;
    logic [7:0]  rdata;
  } frcct_state_t;

  frcct_state_t st;
  frcct_state_t next_st;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
    return a == want;
  endfunction

  logic       tick;
  logic       ext_edge;
  logic [2:0] div_mask;
  logic [1:0] cap_edge;
  logic [1:0] cmp_match;
  logic [1:0] cap_edg_sel;
  logic       pulse_mode;

  always_comb begin
    next_st = st;
    pulse_mode = st.ctrl2[frcct_pkg::C2_OPM] | st.ctrl2[frcct_pkg::C2_PWM];
    cap_edg_sel = {st.ctrl2[frcct_pkg::C2_CAP2_EDG], st.ctrl1[frcct_pkg::C1_CAP1_EDG]};

    // Synchroniser, second stage only feeds the edge detector
    next_st.ext_s1 = ext_clock_pin;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_prev = st.ext_s2;  // see (R8)
    ext_edge = st.ctrl2[frcct_pkg::C2_EXT_EDG] ? (st.ext_s2 & ~st.ext_prev)
                                                : (~st.ext_s2 & st.ext_prev);  // see (R7)

    case (st.ctrl2[frcct_pkg::C2_CLK_LSB +: 2])
      2'h0:    div_mask = frcct_pkg::DIV2_MASK;
      2'h1:    div_mask = frcct_pkg::DIV4_MASK;
      2'h2:    div_mask = frcct_pkg::DIV8_MASK;
      default: div_mask = frcct_pkg::DIV8_MASK;
    endcase

    // Halt freezes prescaler and counter; wait has no effect
    if (halt) begin  // see (R13)
      tick = 1'b0;
    end else if (st.ctrl2[frcct_pkg::C2_CLK_LSB +: 2] == frcct_pkg::CLK_EXT) begin
      tick = ext_edge;  // see (R6)
    end else begin
      tick = (st.presc & div_mask) == div_mask;  // see (R5)
    end
    if (!halt) begin
      next_st.presc = st.presc + 3'h1;
    end

    if (tick) begin
      next_st.count = st.count + 16'h0001;  // see (R1)
      if (st.count == frcct_pkg::CNT_TOP) begin
        next_st.status[frcct_pkg::ST_OVF] = 1'b1;  // see (R10)
      end
    end

    // Compare on every tick against the current count, except between a compare register's high and low byte writes
    cmp_match[0] = tick && st.count == st.cmp1 && !st.cmp_block[0];
    cmp_match[1] = tick && st.count == st.cmp2 && !st.cmp_block[1];
    for (int i = 0; i < 2; i++) begin
      if (cmp_match[i]) begin
        next_st.status[frcct_pkg::ST_CMP1 + i] = 1'b1;  // see (R21)
        next_st.pin[i] = st.ctrl1[frcct_pkg::C1_OLVL1 + i];
      end
    end

    // Capture pins are always watched
    next_st.cap_prev = capture_pin;  // see (R20)
    for (int i = 0; i < 2; i++) begin
      cap_edge[i] = cap_edg_sel[i] ? (capture_pin[i] & ~st.cap_prev[i])
                                   : (~capture_pin[i] & st.cap_prev[i]);  // see (R14)
    end
    if (pulse_mode) begin
      cap_edge[0] = 1'b0;  // see (R19)
    end
    if (cap_edge[0] && !st.cap_block[0]) begin
      next_st.cap1 = st.count;  // see (R18)
      next_st.status[frcct_pkg::ST_CAP1] = 1'b1;
    end
    if (cap_edge[1] && !st.cap_block[1]) begin
      next_st.cap2 = st.count;  // see (R18)
      next_st.status[frcct_pkg::ST_CAP2] = 1'b1;
    end

    next_st.rdata = 8'h00;
    if (rd) begin
      case (addr)
        frcct_pkg::ADDR_CNT_HI, frcct_pkg::ADDR_ALT_HI: begin
          next_st.rdata = st.lo_held ? st.count[15:8] : st.count[15:8];
          if (!st.lo_held) begin
            next_st.lo_buf = st.count[7:0];  // see (R2)
            next_st.lo_held = 1'b1;
          end
        end
        frcct_pkg::ADDR_CNT_LO, frcct_pkg::ADDR_ALT_LO: begin
          next_st.rdata = st.lo_held ? st.lo_buf : st.count[7:0];  // see (R3)
          next_st.lo_held = 1'b0;
        end
        frcct_pkg::ADDR_CAP1_HI: begin
          next_st.rdata = st.cap1[15:8];
          next_st.cap_block[0] = 1'b1;  // see (R17)
        end
        frcct_pkg::ADDR_CAP1_LO: begin
          next_st.rdata = st.cap1[7:0];
          next_st.cap_block[0] = 1'b0;
        end
        frcct_pkg::ADDR_CAP2_HI: begin
          next_st.rdata = st.cap2[15:8];
          next_st.cap_block[1] = 1'b1;  // see (R17)
        end
        frcct_pkg::ADDR_CAP2_LO: begin
          next_st.rdata = st.cap2[7:0];
          next_st.cap_block[1] = 1'b0;
        end
        frcct_pkg::ADDR_CMP1_HI:  next_st.rdata = st.cmp1[15:8];
        frcct_pkg::ADDR_CMP1_LO:  next_st.rdata = st.cmp1[7:0];
        frcct_pkg::ADDR_CMP2_HI:  next_st.rdata = st.cmp2[15:8];
        frcct_pkg::ADDR_CMP2_LO:  next_st.rdata = st.cmp2[7:0];
        frcct_pkg::ADDR_CTRL_ONE: next_st.rdata = st.ctrl1;
        frcct_pkg::ADDR_CTRL_TWO: next_st.rdata = st.ctrl2;
        frcct_pkg::ADDR_STATUS: begin
          next_st.rdata = {3'h0, st.status};
          next_st.armed = st.status;  // see (R12)
        end
        default: next_st.rdata = 8'h00;
      endcase
    end

    if (wr) begin
      case (addr)
        frcct_pkg::ADDR_CNT_LO, frcct_pkg::ADDR_ALT_LO: begin
          next_st.count = frcct_pkg::CNT_RELOAD;  // see (R4)
        end
        frcct_pkg::ADDR_CMP1_HI: begin
          next_st.cmp1[15:8] = wdata;  // see (R22)
          next_st.cmp_block[0] = 1'b1;
        end
        frcct_pkg::ADDR_CMP1_LO: begin
          next_st.cmp1[7:0] = wdata;
          next_st.cmp_block[0] = 1'b0;
        end
        frcct_pkg::ADDR_CMP2_HI: begin
          next_st.cmp2[15:8] = wdata;
          next_st.cmp_block[1] = 1'b1;
        end
        frcct_pkg::ADDR_CMP2_LO: begin
          next_st.cmp2[7:0] = wdata;
          next_st.cmp_block[1] = 1'b0;
        end
        frcct_pkg::ADDR_CTRL_ONE: next_st.ctrl1 = wdata;
        frcct_pkg::ADDR_CTRL_TWO: next_st.ctrl2 = wdata;
        default: next_st.ctrl1 = next_st.ctrl1;
      endcase
    end

    // Two-step flag clears; a new event in the same cycle wins
    if ((rd || wr) && hit(addr, frcct_pkg::ADDR_CNT_LO) && st.armed[frcct_pkg::ST_OVF]) begin
      if (!(tick && st.count == frcct_pkg::CNT_TOP)) begin
        next_st.status[frcct_pkg::ST_OVF] = 1'b0;  // see (R12)
      end
      next_st.armed[frcct_pkg::ST_OVF] = 1'b0;
    end
    if ((rd || wr) && hit(addr, frcct_pkg::ADDR_CAP1_LO) && st.armed[frcct_pkg::ST_CAP1]) begin
      if (!(cap_edge[0] && !st.cap_block[0])) begin
        next_st.status[frcct_pkg::ST_CAP1] = 1'b0;  // see (R16)
      end
      next_st.armed[frcct_pkg::ST_CAP1] = 1'b0;
    end
    if ((rd || wr) && hit(addr, frcct_pkg::ADDR_CAP2_LO) && st.armed[frcct_pkg::ST_CAP2]) begin
      if (!(cap_edge[1] && !st.cap_block[1])) begin
        next_st.status[frcct_pkg::ST_CAP2] = 1'b0;  // see (R16)
      end
      next_st.armed[frcct_pkg::ST_CAP2] = 1'b0;
    end
    if ((rd || wr) && hit(addr, frcct_pkg::ADDR_CMP1_LO) && st.armed[frcct_pkg::ST_CMP1]) begin
      if (!cmp_match[0]) begin
        next_st.status[frcct_pkg::ST_CMP1] = 1'b0;
      end
      next_st.armed[frcct_pkg::ST_CMP1] = 1'b0;
    end
    if ((rd || wr) && hit(addr, frcct_pkg::ADDR_CMP2_LO) && st.armed[frcct_pkg::ST_CMP2]) begin
      if (!cmp_match[1]) begin
        next_st.status[frcct_pkg::ST_CMP2] = 1'b0;
      end
      next_st.armed[frcct_pkg::ST_CMP2] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.count <= frcct_pkg::CNT_RELOAD;  // see (R4)
      st.cmp1 <= frcct_pkg::CMP_RESET;  // see (R22)
      st.cmp2 <= frcct_pkg::CMP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign compare_pin = st.pin;
  assign compare_pin_oe_n = ~{st.ctrl2[frcct_pkg::C2_CMP2_OE],
                              st.ctrl2[frcct_pkg::C2_CMP1_OE]};  // see (R21)
  // Pending flags reach the line once enabled and unmasked
  assign timer_irq = !global_irq_mask && (
    (st.ctrl1[frcct_pkg::C1_OVF_IE] && st.status[frcct_pkg::ST_OVF]) ||  // see (R11)
    (st.ctrl1[frcct_pkg::C1_CAP_IE] &&
     |st.status[frcct_pkg::ST_CAP2:frcct_pkg::ST_CAP1]) ||  // see (R15)
    (st.ctrl1[frcct_pkg::C1_CMP_IE] &&
     |st.status[frcct_pkg::ST_CMP2:frcct_pkg::ST_CMP1]));  // see (R23)

endmodule
`default_nettype wire

/* test/frcct_timer_sva.sv */
`default_nettype none
module frcct_timer_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       global_irq_mask,
  input wire logic [1:0] compare_pin_oe_n,
  input wire logic       timer_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] oe_bits;
  logic       ctl2_wr;
  assign oe_bits = ~wdata[5:4];
  assign ctl2_wr = wr && addr == frcct_pkg::ADDR_CTRL_TWO;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_reload_hi;
    (wr && addr == frcct_pkg::ADDR_CNT_LO) ##1 (rd && addr == frcct_pkg::ADDR_CNT_HI);
  endsequence
  sequence s_wr_rd(logic [4:0] a);
    (wr && addr == a) ##1 (rd && addr == a);
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_unmapped_zero: assert property (rd && addr > frcct_pkg::ADDR_STATUS |=> !rdata)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (global_irq_mask |-> !timer_irq)
    else $error("interrupt while masked");
  a_reload_high: assert property (s_reload_hi |=> rdata == 8'hff)
    else $error("reload high byte wrong");
  a_cmp_one_keep: assert property (s_wr_rd(frcct_pkg::ADDR_CMP1_LO)
    |=> rdata == $past(wdata, 2)) else $error("compare one byte lost");
  a_cmp_two_keep: assert property (s_wr_rd(frcct_pkg::ADDR_CMP2_HI)
    |=> rdata == $past(wdata, 2)) else $error("compare two byte lost");
  a_oe_from_ctrl: assert property (ctl2_wr |=> compare_pin_oe_n == $past(oe_bits))
    else $error("output enable wrong");
  a_oe_only_wr: assert property ($changed(compare_pin_oe_n) |-> $past(ctl2_wr))
    else $error("output enable moved alone");
endmodule
bind frcct_timer frcct_timer_sva i_sva (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .global_irq_mask(global_irq_mask), .compare_pin_oe_n(compare_pin_oe_n),
  .timer_irq(timer_irq));
`default_nettype wire

/* test/frcct_far_end.sv */
`default_nettype none
module frcct_far_end (
  input  wire logic       clk,
  input  wire logic [1:0] compare_pin,
  input  wire logic [1:0] compare_pin_oe_n,
  output logic            ext_clock_pin,
  output logic      [1:0] capture_pin,
  output logic      [1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven compare pins sit at the pull-down
  assign pin_level = compare_pin & ~compare_pin_oe_n;
  initial begin
    ext_clock_pin <= 1'b0;
    capture_pin <= 2'b00;
  end
  task automatic set_ext(input logic v);
    repeat (6) @(posedge clk);
    ext_clock_pin <= v;
  endtask
  task automatic pulse_cap(input logic [1:0] ch);
    capture_pin <= ch;
    repeat (4) @(posedge clk);
    capture_pin <= 2'b00;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* test/test_free_running_capture_compare_timer.sv */
`default_nettype none
module test_free_running_capture_compare_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        halt;
  logic        global_irq_mask;
  logic [7:0]  rdata, d;
  logic        ext_clock_pin, timer_irq;
  logic [1:0]  capture_pin, compare_pin, compare_pin_oe_n, pin_level;
  logic [15:0] c1, c3;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #50 clk = ~clk;
  frcct_timer i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .halt(halt), .global_irq_mask(global_irq_mask),
    .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin), .compare_pin(compare_pin),
    .compare_pin_oe_n(compare_pin_oe_n), .timer_irq(timer_irq));
  frcct_far_end i_far (.clk(clk), .compare_pin(compare_pin), .pin_level(pin_level),
    .compare_pin_oe_n(compare_pin_oe_n), .ext_clock_pin(ext_clock_pin),
    .capture_pin(capture_pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // Strobe left high so a following access can go back to back
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic rd_pair(input logic [4:0] a, output logic [15:0] v);
    rd_reg(a, v[15:8]);
    rd_reg(a + 5'h01, v[7:0]);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    addr <= 5'h00;
    wdata <= 8'h00;
    wr <= 1'b0;
    rd <= 1'b0;
    halt <= 1'b0;
    global_irq_mask <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd_reg(frcct_pkg::ADDR_CMP1_HI + 5'(i), d);
      chk(d, i[0] ? 8'h00 : 8'h80);
    end
    rd_reg(5'h1f, d);
    chk(d, 8'h00);
    chk(8'(compare_pin_oe_n), 8'h03);
    for (int s = 0; s < 3; s++) begin
      wr_reg(frcct_pkg::ADDR_CTRL_ONE, 8'h01);
      wr_reg(frcct_pkg::ADDR_CTRL_TWO, 8'(s));
      wr_reg(frcct_pkg::ADDR_CNT_LO, 8'h00);
      tick(32 << s);
      rd_pair(frcct_pkg::ADDR_CNT_HI, c1);
      chk(c1[15:8], 8'h00);
      chk_rng(c1[7:0], 8'h0b, 8'h0d);
      rd_reg(frcct_pkg::ADDR_ALT_HI, d);
      tick(40);
      rd_reg(frcct_pkg::ADDR_ALT_LO, d);
      rd_reg(frcct_pkg::ADDR_ALT_LO, c1[7:0]);
      chk_rng(c1[7:0] - d, 8'((44 >> (s + 1)) - 1), 8'((44 >> (s + 1)) + 1));
      rd_reg(frcct_pkg::ADDR_STATUS, d);
      chk(d & 8'h10, 8'h10);
      chk(8'(timer_irq), 8'h01);
      global_irq_mask <= 1'b1;
      tick(1);
      chk(8'(timer_irq), 8'h00);
      global_irq_mask <= 1'b0;
      rd_reg(frcct_pkg::ADDR_ALT_LO, d);
      rd_reg(frcct_pkg::ADDR_STATUS, d);
      chk(d & 8'h10, 8'h10);
      rd_reg(frcct_pkg::ADDR_CNT_LO, d);
      rd_reg(frcct_pkg::ADDR_STATUS, d);
      chk(d & 8'h10, 8'h00);
    end
    for (int e = 0; e < 2; e++) begin
      i_far.set_ext(1'b0);
      wr_reg(frcct_pkg::ADDR_CTRL_TWO, {5'h00, e[0], 2'h3});
      wr_reg(frcct_pkg::ADDR_CNT_LO, 8'h00);
      tick(1);
      repeat (4) begin
        i_far.set_ext(1'b1);
        i_far.set_ext(1'b0);
      end
      i_far.set_ext(1'b1);
      tick(8);
      rd_pair(frcct_pkg::ADDR_CNT_HI, c1);
      chk(c1[7:0], {7'h00, e[0]});
    end
    wr_reg(frcct_pkg::ADDR_CTRL_TWO, 8'h00);
    wr_reg(frcct_pkg::ADDR_CTRL_ONE, 8'h0a);
    halt <= 1'b1;
    tick(4);
    rd_pair(frcct_pkg::ADDR_CNT_HI, c1);
    i_far.pulse_cap(2'b01);
    rd_pair(frcct_pkg::ADDR_CNT_HI, c3);
    chk(c3[7:0], c1[7:0]);
    rd_reg(frcct_pkg::ADDR_STATUS, d);
    chk(d & 8'h01, 8'h01);
    chk(8'(timer_irq), 8'h01);
    rd_reg(frcct_pkg::ADDR_CAP1_HI, d);
    chk(d, c1[15:8]);
    halt <= 1'b0;
    tick(20);
    i_far.pulse_cap(2'b01);
    rd_reg(frcct_pkg::ADDR_CAP1_LO, d);
    chk(d, c1[7:0]);
    rd_reg(frcct_pkg::ADDR_STATUS, d);
    chk(d & 8'h01, 8'h00);
    halt <= 1'b1;
    tick(4);
    rd_pair(frcct_pkg::ADDR_CNT_HI, c1);
    i_far.pulse_cap(2'b01);
    rd_reg(frcct_pkg::ADDR_STATUS, d);
    rd_pair(frcct_pkg::ADDR_CAP1_HI, c3);
    chk(c3[15:8], c1[15:8]);
    chk(c3[7:0], c1[7:0]);
    halt <= 1'b0;
    wr_reg(frcct_pkg::ADDR_CTRL_TWO, 8'h40);
    tick(1);
    i_far.pulse_cap(2'b11);
    rd_reg(frcct_pkg::ADDR_STATUS, d);
    chk(d & 8'h03, 8'h02);
    wr_reg(frcct_pkg::ADDR_CTRL_TWO, 8'h10);
    wr_reg(frcct_pkg::ADDR_CTRL_ONE, 8'h14);
    wr_reg(frcct_pkg::ADDR_CMP1_HI, 8'hff);
    wr_reg(frcct_pkg::ADDR_CMP1_LO, 8'hfe);
    rd_reg(frcct_pkg::ADDR_CMP1_LO, d);
    chk(d, 8'hfe);
    chk(8'(compare_pin_oe_n), 8'h02);
    wr_reg(frcct_pkg::ADDR_CNT_LO, 8'h00);
    rd_reg(frcct_pkg::ADDR_CNT_HI, d);
    chk(d, 8'hff);
    tick(12);
    chk(8'(pin_level), 8'h01);
    rd_reg(frcct_pkg::ADDR_STATUS, d);
    chk(d & 8'h04, 8'h04);
    chk(8'(timer_irq), 8'h01);
    wr_reg(frcct_pkg::ADDR_CMP2_HI, 8'h12);
    rd_reg(frcct_pkg::ADDR_CMP2_HI, d);
    chk(d, 8'h12);
    // Let the checker see the last read before the run ends
    tick(2);
    close_out();
  end
endmodule
`default_nettype wire
